/* host_irq_input.sv */
`timescale 1ns/100ps
module host_irq_input (
	input  wire logic pin_level_in,
	input  wire logic pin_drive_in,
	output logic      line_out
);
	// Board pull-up holds the shared line high whenever no one drives it
	assign line_out = pin_drive_in ? pin_level_in : 1'b1;
endmodule

/* irq_output_deassert_ctrl.sv */
// How it works
// - Bits 31:24 hold the quiet interval length in 10 us steps.
// - Writing zero length stops the interval function and clears its counter.
// - After a zero write, withheld interrupts reach the pin at once.
// - A new nonzero length applies to every later interval.
// - The power event source bypasses the quiet interval entirely.
// - Writing one to bit 14 restarts the interval; the bit self-clears.
// - Bit 13 shows an active interval; enabled source interrupts are withheld then.
// - Bit 12 shows the master interrupt line, ignoring enable and interval.
// - Bit 8 clear keeps the pin inactive; source flags are untouched.
// - Bit 4 picks polarity: zero active low, one active high.
// - Bit 0 picks driver: zero open drain, one push-pull.
// - Open drain ignores polarity and always drives active low.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "irq_output_params.svh"

module irq_output_deassert_ctrl #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned LEN_WIDTH   = 8
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        source_irq_in,
	input  wire logic        power_event_in,
	input  wire logic        irq_pin_in,
	output logic             irq_pin_out,
	output logic             irq_pin_oe_out
);
	irq_output_pkg::apb_req_t   req;
	irq_output_pkg::pin_cfg_t   cfg_reg;
	irq_output_pkg::pin_state_t state_reg;
	irq_output_pkg::pin_state_t state_next;

	logic [LEN_WIDTH-1:0] quiet_count_reg;
	logic                 quiet_interval_active_reg;
	logic                 quiet_interval_restart;
	logic                 length_zero_write;
	logic                 cfg_write;
	logic                 master_line;
	logic                 pin_request;
	logic                 pin_active;
	logic                 tick;
	logic                 access_done;
	logic                 addr_hit;
	logic                 power_event_reg;

	assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
		addr: paddr_in, wdata: pwdata_in};

	function automatic logic drive_level(input logic active, input logic push_pull,
		input logic polarity);
		// Open drain always signals by pulling low
		drive_level = push_pull ? (active ~^ polarity) : 1'b0;
	endfunction

	// One wait state: pready rises in the second access cycle from a flop
	assign access_done = req.sel && req.enable && pready_out;
	assign addr_hit    = (req.addr == `CFG_REG_OFFSET);
	assign cfg_write   = access_done && req.write && addr_hit;
	assign quiet_interval_restart = cfg_write && req.wdata[`CFG_RESTART_BIT];
	assign length_zero_write = cfg_write
		&& (req.wdata[`CFG_LEN_MSB:`CFG_LEN_LSB] == '0);

	assign master_line = source_irq_in || power_event_in;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pready_out <= 1'b0;
		end else begin
			pready_out <= req.sel && req.enable && !pready_out;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pslverr_out <= 1'b0;
		end else begin
			pslverr_out <= req.sel && req.enable && !pready_out && !addr_hit;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cfg_reg <= '0;
		end else if (cfg_write) begin
			cfg_reg.length    <= req.wdata[`CFG_LEN_MSB:`CFG_LEN_LSB];
			cfg_reg.enable    <= req.wdata[`CFG_ENABLE_BIT];
			cfg_reg.polarity  <= req.wdata[`CFG_POLARITY_BIT];
			cfg_reg.push_pull <= req.wdata[`CFG_PUSHPULL_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prdata_out <= `CFG_RESET_VALUE;
		end else if (req.sel && !req.enable && !req.write && addr_hit) begin
			prdata_out <= {cfg_reg.length, 9'h000, 1'b0,
				quiet_interval_active_reg,
				master_line,
				3'h0, cfg_reg.enable, 3'h0, cfg_reg.polarity, 3'h0,
				cfg_reg.push_pull};
		end else if (req.sel && !req.enable) begin
			prdata_out <= 32'h0000_0000;
		end
	end

	tick_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.restart_in(quiet_interval_restart || state_next == irq_output_pkg::pin_quiet
			&& state_reg != irq_output_pkg::pin_quiet),
		.tick_out  (tick)
	);

	// Interval starts when the pin falls back to inactive with a nonzero length, or on a restart write
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			irq_output_pkg::pin_idle: begin
				if (pin_request) begin
					state_next = irq_output_pkg::pin_asserted;
				end
			end
			irq_output_pkg::pin_asserted: begin
				if (!pin_request) begin
					state_next = (cfg_reg.length != '0)
						? irq_output_pkg::pin_quiet : irq_output_pkg::pin_idle;
				end
			end
			irq_output_pkg::pin_quiet: begin
				if (length_zero_write) begin
					state_next = irq_output_pkg::pin_idle;
				end else if (tick && quiet_count_reg == LEN_WIDTH'(1)
					&& !quiet_interval_restart) begin
					state_next = irq_output_pkg::pin_idle;
				end
			end
			default: state_next = irq_output_pkg::pin_idle;
		endcase
		if (quiet_interval_restart && !length_zero_write) begin
			state_next = irq_output_pkg::pin_quiet;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg <= irq_output_pkg::pin_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counter reloads from the current length on each new interval
	always_ff @(posedge clk_in) begin
		if (reset_in || length_zero_write) begin
			quiet_count_reg <= '0;
		end else if (state_next == irq_output_pkg::pin_quiet
			&& (state_reg != irq_output_pkg::pin_quiet || quiet_interval_restart)) begin
			quiet_count_reg <= quiet_interval_restart
				? req.wdata[`CFG_LEN_MSB:`CFG_LEN_LSB] : cfg_reg.length;
		end else if (tick && quiet_count_reg != '0) begin
			quiet_count_reg <= quiet_count_reg - LEN_WIDTH'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			quiet_interval_active_reg <= 1'b0;
		end else begin
			quiet_interval_active_reg <= (state_next == irq_output_pkg::pin_quiet);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			power_event_reg <= 1'b0;
		end else begin
			power_event_reg <= power_event_in;
		end
	end

	// Withheld sources stay pending in their flags; only the pin is held quiet
	assign pin_request = cfg_reg.enable && (power_event_reg
		|| (source_irq_in && state_reg != irq_output_pkg::pin_quiet));

	assign pin_active = (state_next == irq_output_pkg::pin_asserted)
		|| (cfg_reg.enable && power_event_reg);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_pin_out <= 1'b1;
		end else begin
			irq_pin_out <= cfg_reg.push_pull
				? drive_level(pin_active, 1'b1, cfg_reg.polarity)
				: 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_pin_oe_out <= 1'b0;
		end else begin
			irq_pin_oe_out <= cfg_reg.push_pull || pin_active;
		end
	end

	logic unused_pin;
	assign unused_pin = irq_pin_in;
endmodule

/* irq_output_deassert_ctrl_properties.sv */
`timescale 1ns/100ps
module irq_output_deassert_ctrl_properties #(
	parameter int unsigned TICK_CYCLES = 1000
) (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        source_irq_in,
	input wire logic        power_event_in,
	input wire logic        irq_pin_in,
	input wire logic        irq_pin_out,
	input wire logic        irq_pin_oe_out
);
	irq_output_pkg::pin_cfg_t cfg_reg;
	irq_output_pkg::pin_cfg_t cfg_d_reg;
	logic                     mst_reg;
	logic                     mst_d_reg;
	logic                     pin_act;
	logic                     steady;
	logic                     rd_cfg;
	assign pin_act = cfg_reg.push_pull ? (irq_pin_out == cfg_reg.polarity) : irq_pin_oe_out;
	assign steady = (cfg_reg == cfg_d_reg);
	assign rd_cfg = pready_out && !pwrite_in && paddr_in == 12'h054;
	// Shadow of the written config, taken at the completing edge
	always_ff @(posedge clk_in) begin
		if (reset_in)
			cfg_reg <= '0;
		else if (pready_out && psel_in && penable_in && pwrite_in && paddr_in == 12'h054)
			cfg_reg <= '{pwdata_in[31:24], pwdata_in[8], pwdata_in[4], pwdata_in[0]};
	end
	// Pin output lags config by one edge, so only steady config is judged
	always_ff @(posedge clk_in) begin
		cfg_d_reg <= cfg_reg;
		mst_reg <= source_irq_in | power_event_in;
		mst_d_reg <= mst_reg;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_setup; psel_in && !penable_in; endsequence
	sequence s_wait; psel_in && penable_in && !pready_out; endsequence
	property p_wait; s_setup ##1 s_wait |=> pready_out; endproperty
	property p_pulse; pready_out |=> !pready_out; endproperty
	property p_err; pready_out |-> (pslverr_out == (paddr_in != 12'h054)); endproperty
	property p_len; rd_cfg |-> prdata_out[31:24] == cfg_reg.length; endproperty
	property p_ro; rd_cfg |-> prdata_out[23:14] == 10'h000; endproperty
	property p_mst;
		rd_cfg && mst_reg == mst_d_reg && mst_reg == (source_irq_in | power_event_in)
			|-> prdata_out[12] == mst_reg;
	endproperty
	property p_en; steady && !cfg_reg.enable |-> !pin_act; endproperty
	property p_pp; steady && cfg_reg.push_pull |-> irq_pin_oe_out; endproperty
	property p_od; steady && !cfg_reg.push_pull && irq_pin_oe_out |-> !irq_pin_out; endproperty
	property p_pwr;
		steady && cfg_reg.enable && power_event_in && $past(power_event_in)
			&& $past(power_event_in, 2) |-> pin_act;
	endproperty
	a_wait: assert property (p_wait) else $error("pready late");
	a_pulse: assert property (p_pulse) else $error("pready long");
	a_err: assert property (p_err) else $error("pslverr wrong");
	a_len: assert property (p_len) else $error("length readback");
	a_ro: assert property (p_ro) else $error("restart bit reads set");
	a_mst: assert property (p_mst) else $error("master bit wrong");
	a_en: assert property (p_en) else $error("pin active while disabled");
	a_pp: assert property (p_pp) else $error("push-pull not driven");
	a_od: assert property (p_od) else $error("open drain drives high");
	a_pwr: assert property (p_pwr) else $error("power event held back");
endmodule

/* irq_output_deassert_ctrl_tb.sv */
`timescale 1ns/100ps
module irq_output_deassert_ctrl_tb;
	localparam logic [11:0] A = 12'h054;
	logic clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0, src = 0, pwr = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, prdata;
	logic pready, pslverr, pin, oe, line;
	int errors = 0, samples_checked = 0, cycles = 0;
	always #5 clk_in = ~clk_in;
	irq_output_deassert_ctrl #(.TICK_CYCLES(4)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.source_irq_in(src), .power_event_in(pwr), .irq_pin_in(line), .irq_pin_out(pin),
		.irq_pin_oe_out(oe));
	host_irq_input host (.pin_level_in(pin), .pin_drive_in(oe), .line_out(line));
	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
		end
		rd = prdata;
		psel <= 0;
		penable <= 0;
		// One idle edge so a following call never re-raises psel in the same step
		@(posedge clk_in);
	endtask
	task automatic line_is(input logic exp);
		repeat (3) @(posedge clk_in);
		check({31'h0, line}, {31'h0, exp});
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		repeat (4) @(posedge clk_in);
		reset_in <= 0;
		@(posedge clk_in);
		apb(0, A, 0); check(rd, 32'h0);
		apb(0, 12'h058, 0); check(rd, 32'h0);
		apb(1, A, 32'h0000_0111); src <= 1; line_is(1);
		src <= 0; line_is(0);
		apb(1, A, 32'h0000_0101); src <= 1; line_is(0);
		apb(1, A, 32'h0000_0110); line_is(0);
		src <= 0; line_is(1);
		apb(1, A, 32'h0800_0111); src <= 1; line_is(1);
		src <= 0; line_is(0);
		src <= 1; line_is(0);
		apb(0, A, 0); check(rd & 32'hFF00_7000, 32'h0800_3000);
		apb(1, A, 32'h0000_0111); line_is(1);
		apb(0, A, 0); check(rd & 32'hFF00_2000, 32'h0);
		src <= 0; apb(1, A, 32'h0800_0111); line_is(0);
		apb(1, A, 32'h0800_4111); apb(0, A, 0);
		check(rd & 32'hFF00_7000, 32'h0800_2000);
		pwr <= 1; line_is(1);
		pwr <= 0; src <= 1; line_is(0);
		// Eight ticks of four cycles end the interval; the held source then shows
		repeat (40) @(posedge clk_in);
		check({31'h0, line}, 32'h1);
		apb(1, A, 32'h0000_0011); line_is(0);
		apb(0, A, 0); check(rd & 32'h0000_1000, 32'h0000_1000);
		finish_test();
	end
endmodule
bind irq_output_deassert_ctrl irq_output_deassert_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .source_irq_in(source_irq_in),
	.power_event_in(power_event_in), .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out),
	.irq_pin_oe_out(irq_pin_oe_out));

/* irq_output_params.svh */
`ifndef IRQ_OUTPUT_PARAMS_SVH
`define IRQ_OUTPUT_PARAMS_SVH

`define CFG_REG_OFFSET     12'h054
`define CFG_LEN_MSB        31
`define CFG_LEN_LSB        24
`define CFG_RESTART_BIT    14
`define CFG_ACTIVE_BIT     13
`define CFG_MASTER_BIT     12
`define CFG_ENABLE_BIT     8
`define CFG_POLARITY_BIT   4
`define CFG_PUSHPULL_BIT   0
`define CFG_RESET_VALUE    32'h0000_0000
`define CLK_FREQ_MHZ       100
`define TICK_TIME_US       10
`define TICK_CYCLES        (`TICK_TIME_US * `CLK_FREQ_MHZ)

`endif

/* irq_output_pkg.sv */
package irq_output_pkg;

	typedef struct packed {
		logic [7:0] length;
		logic       enable;
		logic       polarity;
		logic       push_pull;
	} pin_cfg_t;

	typedef struct packed {
		logic       sel;
		logic       enable;
		logic       write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_t;

	typedef enum logic [1:0] {
		pin_idle,
		pin_asserted,
		pin_quiet
	} pin_state_t;

endpackage

/* tick_timebase.sv */
`timescale 1ns/100ps
`include "irq_output_params.svh"

module tick_timebase #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic restart_in,
	output logic      tick_out
);
	localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

	logic [CW-1:0] count_reg;

	// Restart realigns the timebase so a fresh interval is a full step count long
	always_ff @(posedge clk_in) begin
		if (reset_in || restart_in) begin
			count_reg <= '0;
		end else if (count_reg == CW'(TICK_CYCLES - 1)) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || restart_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (count_reg == CW'(TICK_CYCLES - 1));
		end
	end
endmodule
